// [svsc_top.sv]
// Stereo volume serial control: three-wire write port, volume
// register, power-up sequence and crossing-gated level updates.
// Assumes all pin inputs except rst_n are asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "svsc_cfg.svh"

module svsc_top #(
    parameter int unsigned POR_CYC        = `SVSC_POR_CYC,
    parameter int unsigned ZC_TIMEOUT_CYC = `SVSC_ZC_TIMEOUT_CYC,
    parameter int unsigned CAL_CYC        = `SVSC_CAL_CYC
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     sclk,
    input  wire logic                     cs_n,
    input  wire logic                     serial_in,
    output logic                          serial_out,
    output logic                          serial_out_en,
    input  wire logic                     mute_n,
    input  wire logic                     supply_low,
    input  wire logic                     crossing_detect_enable,
    input  wire logic                     sign_right,
    input  wire logic                     sign_left,
    output logic [`SVSC_WORD_W-1:0]       volume_word,
    output logic [`SVSC_CODE_W-1:0]       gain_right,
    output logic [`SVSC_CODE_W-1:0]       gain_left,
    output logic                          soft_mute_right,
    output logic                          soft_mute_left,
    output logic                          hw_mute,
    output logic                          cal_busy,
    output logic                          por_busy
);

    // ------------------------------------------------------------
    // Input synchronisation and edges
    // ------------------------------------------------------------
    logic [`SVSC_SYNC_W-1:0] in_s;
    logic [`SVSC_SYNC_W-1:0] in_d_q;

    svsc_sync #(
        .WIDTH   (`SVSC_SYNC_W),
        .RST_VAL (`SVSC_SYNC_RST)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({cs_n, sclk, serial_in, mute_n, supply_low,
                    crossing_detect_enable, sign_right, sign_left}),
        .sync_out (in_s)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            in_d_q <= `SVSC_SYNC_RST;
        end else begin
            in_d_q <= in_s;
        end
    end

    logic       cs_s;
    logic       sin_s;
    logic       mute_s;
    logic       low_s;
    logic       crossing_detect_enable_s;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;
    logic       cs_fall;
    logic       seq_start;
    logic [1:0] zc_edge;

    assign cs_s      = in_s[7];
    assign sin_s     = in_s[5];
    assign mute_s    = in_s[4];
    assign low_s     = in_s[3];
    assign crossing_detect_enable_s    = in_s[2];
    assign sclk_rise = in_s[6] & ~in_d_q[6];
    assign sclk_fall = ~in_s[6] & in_d_q[6];
    assign cs_rise   = cs_s & ~in_d_q[7];
    assign cs_fall   = ~cs_s & in_d_q[7];
    // Mute falling or supply recovering restarts calibration
    assign seq_start = (~mute_s & in_d_q[4]) | (~low_s & in_d_q[3]);
    assign zc_edge   = in_s[1:0] ^ in_d_q[1:0];

    // ------------------------------------------------------------
    // Power sequence
    // ------------------------------------------------------------
    svsc_pkg::svsc_pwr_t       pwr_q;
    logic [`SVSC_CNT_W-1:0]    seq_cnt_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pwr_q     <= svsc_pkg::pwr_por;
            seq_cnt_q <= '0;
        end else if (seq_start && pwr_q != svsc_pkg::pwr_por) begin
            // Mute at power-on must not cut the reset interval short
            pwr_q     <= svsc_pkg::pwr_cal;
            seq_cnt_q <= '0;
        end else begin
            case (pwr_q)
                svsc_pkg::pwr_por: begin
                    if (seq_cnt_q == `SVSC_CNT_W'(POR_CYC - 1)) begin
                        pwr_q     <= svsc_pkg::pwr_cal;
                        seq_cnt_q <= '0;
                    end else begin
                        seq_cnt_q <= seq_cnt_q + `SVSC_CNT_W'(1);
                    end
                end
                svsc_pkg::pwr_cal: begin
                    if (seq_cnt_q == `SVSC_CNT_W'(CAL_CYC - 1)) begin
                        pwr_q <= svsc_pkg::pwr_run;
                    end else begin
                        seq_cnt_q <= seq_cnt_q + `SVSC_CNT_W'(1);
                    end
                end
                svsc_pkg::pwr_run: begin
                    pwr_q <= svsc_pkg::pwr_run;
                end
                default: begin
                    pwr_q <= svsc_pkg::pwr_por;
                end
            endcase
        end
    end

    logic accept;
    assign accept   = (pwr_q != svsc_pkg::pwr_por) & ~seq_start;
    assign cal_busy = (pwr_q == svsc_pkg::pwr_cal);
    assign por_busy = (pwr_q == svsc_pkg::pwr_por);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hw_mute <= 1'b1;
        end else begin
            hw_mute <= ~mute_s | low_s;
        end
    end

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    logic [`SVSC_WORD_W-1:0] shreg_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || seq_start) begin
            shreg_q <= '0;
        end else if (accept && sclk_rise && !cs_s) begin
            shreg_q <= {shreg_q[`SVSC_WORD_W-2:0], sin_s};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            serial_out_en <= ~cs_s;
            if (cs_fall || (sclk_fall && !cs_s)) begin
                serial_out <= shreg_q[`SVSC_WORD_W-1];
            end
        end
    end

    logic latch;
    assign latch = accept & cs_rise;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || seq_start) begin
            volume_word <= '0;
        end else if (latch) begin
            volume_word <= shreg_q;
        end
    end

    // ------------------------------------------------------------
    // Crossing-gated level update
    // ------------------------------------------------------------
    logic                    pend_q   [2];
    logic [1:0]              zc_cnt_q [2];
    logic [`SVSC_CODE_W-1:0] gain_q   [2];
    logic [`SVSC_CNT_W-1:0]  to_cnt_q;
    logic                    timeout;

    assign timeout = (to_cnt_q == `SVSC_CNT_W'(ZC_TIMEOUT_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (!rst_n || seq_start || latch) begin
            to_cnt_q <= '0;
        end else if ((pend_q[0] || pend_q[1]) && !timeout) begin
            to_cnt_q <= to_cnt_q + `SVSC_CNT_W'(1);
        end
    end

    // Channel 1 is right (first byte), channel 0 left
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        always_ff @(posedge sys_clk) begin
            if (!rst_n || seq_start) begin
                pend_q[ch]   <= 1'b0;
                zc_cnt_q[ch] <= 2'h0;
                gain_q[ch]   <= `SVSC_CODE_MUTE;
            end else if (latch) begin
                pend_q[ch]   <= 1'b1;
                zc_cnt_q[ch] <= 2'h0;
            end else if (pend_q[ch]) begin
                if (!crossing_detect_enable_s || zc_cnt_q[ch] == 2'h2 || timeout) begin
                    gain_q[ch] <= volume_word[ch*8 +: 8];
                    pend_q[ch] <= 1'b0;
                end else if (zc_edge[ch]) begin
                    zc_cnt_q[ch] <= zc_cnt_q[ch] + 2'h1;
                end
            end
        end
    end

    assign gain_right      = gain_q[1];
    assign gain_left       = gain_q[0];
    assign soft_mute_right = (gain_q[1] == `SVSC_CODE_MUTE);
    assign soft_mute_left  = (gain_q[0] == `SVSC_CODE_MUTE);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_MUTE_CLEAR: assert property (
        ($fell(mute_s) && !por_busy) |=> (shreg_q == '0)
            && (volume_word == '0) && cal_busy)
        else $error("mute did not restart power-up");

    AST_POR_IGNORE: assert property (
        (por_busy && !seq_start) |=> $stable(shreg_q)
            && $stable(volume_word))
        else $error("write taken during power-on reset");

    AST_LOW_MUTE: assert property (
        low_s |=> hw_mute)
        else $error("low supply without hardware mute");

    AST_CAL_END: assert property (
        (cal_busy && !seq_start
            && seq_cnt_q == `SVSC_CNT_W'(CAL_CYC - 1))
            |=> pwr_q == svsc_pkg::pwr_run)
        else $error("calibration did not complete");

    AST_SHIFT_IN: assert property (
        (accept && sclk_rise && !cs_s) |=>
            shreg_q == {$past(shreg_q[`SVSC_WORD_W-2:0]), $past(sin_s)})
        else $error("serial input not shifted");

    AST_OUT_BIT: assert property (
        (sclk_fall && !cs_s) |=>
            serial_out == $past(shreg_q[`SVSC_WORD_W-1]))
        else $error("output bit not presented");

    AST_RELEASE: assert property (
        $rose(cs_s) |=> !serial_out_en ##1 !serial_out_en)
        else $error("output driven with select high");

    AST_LATCH: assert property (
        latch |=> volume_word == $past(shreg_q))
        else $error("volume register not loaded");

    AST_HOLD: assert property (
        (cs_s && !seq_start) |=> $stable(shreg_q))
        else $error("shift register moved with select high");

    AST_NO_ZC: assert property (
        (pend_q[1] && !crossing_detect_enable_s && !seq_start && !latch) |=>
            gain_right == $past(volume_word[15:8]) && !pend_q[1])
        else $error("level change delayed with detection off");

endmodule : svsc_top

`default_nettype wire

// [svsc_cfg.svh]
// Constants of the stereo volume serial control block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef SVSC_CFG_SVH
`define SVSC_CFG_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define SVSC_WORD_W         16
`define SVSC_CODE_W         8
`define SVSC_CODE_MUTE      8'h00
`define SVSC_CODE_UNITY     8'hC0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SVSC_CLK_FREQ_MHZ   100
`define SVSC_POR_TIME_US    100
`define SVSC_ZC_TIMEOUT_MS  18
`define SVSC_CAL_TIME_MS    2
`define SVSC_POR_CYC      (`SVSC_POR_TIME_US * `SVSC_CLK_FREQ_MHZ)
`define SVSC_ZC_TIMEOUT_CYC \
    (`SVSC_ZC_TIMEOUT_MS * 1000 * `SVSC_CLK_FREQ_MHZ)
`define SVSC_CAL_CYC (`SVSC_CAL_TIME_MS * 1000 * `SVSC_CLK_FREQ_MHZ)
`define SVSC_CNT_W          21

// ----------------------------------------------------------------
// Synchroniser bundle: cs_n sclk sin mute_n low crossing_detect_enable sgn_r sgn_l
// ----------------------------------------------------------------
`define SVSC_SYNC_W         8
`define SVSC_SYNC_RST       8'h90

`endif

// [svsc_pkg.sv]
// Types of the stereo volume serial control block.
// Assumes nothing of its surroundings.
`default_nettype none

package svsc_pkg;

    // ------------------------------------------------------------
    // Power sequence
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        pwr_por,
        pwr_cal,
        pwr_run
    } svsc_pwr_t;

endpackage : svsc_pkg

`default_nettype wire

// [svsc_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous inputs.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module svsc_sync #(
    parameter int unsigned           WIDTH   = 1,
    parameter logic [WIDTH-1:0]      RST_VAL = '0
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic [WIDTH-1:0]    async_in,
    output logic      [WIDTH-1:0]    sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : svsc_sync

`default_nettype wire

// [svsc_host_model.sv]
// Host model driving the three-wire serial port of the volume block.
// Assumes the bench calls frame() just after a sys_clk edge.
`timescale 1ns/100ps
`default_nettype none

module svsc_host_model (
    input  wire logic        sys_clk,
    input  wire logic        sdo,
    output logic             sclk,
    output logic             cs_n,
    output logic             serial_in,
    output logic [15:0]      rd_word
);
    // ------------------------------------------------------------
    // Idle lines: clock still, data inverted after release
    // ------------------------------------------------------------
    initial begin
        sclk      = 1'b0;
        cs_n      = 1'b1;
        serial_in = 1'b0;
        rd_word   = 16'h0000;
    end

    // ------------------------------------------------------------
    // One frame of n pulses, 160 ns clock, MSB first
    // ------------------------------------------------------------
    task automatic frame(input logic [31:0] word, input int n,
                         input logic sel);
        int i;
        cs_n <= ~sel;
        repeat (8) @(posedge sys_clk);
        for (i = n - 1; i >= 0; i--) begin
            serial_in <= word[i];
            repeat (8) @(posedge sys_clk);
            sclk    <= 1'b1;
            rd_word <= {rd_word[14:0], sdo};
            repeat (8) @(posedge sys_clk);
            sclk <= 1'b0;
        end
        repeat (8) @(posedge sys_clk);
        cs_n      <= 1'b1;
        serial_in <= ~serial_in;
        repeat (8) @(posedge sys_clk);
    endtask : frame
endmodule : svsc_host_model

`default_nettype wire

// [tb_stereo_volume_serial_control.sv]
// Self-checking bench of the volume block with a host model.
// Assumes small POR, calibration and timeout parameters.
`timescale 1ns/100ps
`default_nettype none

module tb_stereo_volume_serial_control;
    logic        sys_clk = 1'b0, rst_n = 1'b0, mute_n = 1'b1;
    logic        supply_low = 1'b0, zc_en = 1'b0;
    logic        sgn_r = 1'b0, sgn_l = 1'b0, last_q = 1'b0;
    logic        sclk, cs_n, serial_in, serial_out, serial_out_en;
    logic        sdo_line, sm_r, sm_l, hw_mute, cal_busy, por_busy;
    logic [15:0] volume_word, rd_word, prev_q, w, a;
    logic [7:0]  gain_right, gain_left;
    logic [15:0] corners [4] = '{16'hFF00, 16'hC001, 16'h01C0, 16'h0000};
    int          miscompares = 0, checks = 0, cycles = 0;
    int          seed = 88506, i;

    always #5 sys_clk = ~sys_clk;

    // Released line shows the inverse of its last level
    always_ff @(posedge sys_clk) if (serial_out_en) last_q <= serial_out;
    assign sdo_line = serial_out_en ? serial_out : ~last_q;

    svsc_host_model host (.sys_clk(sys_clk), .sdo(sdo_line),
        .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .rd_word(rd_word));

    svsc_top #(.POR_CYC(60), .ZC_TIMEOUT_CYC(50), .CAL_CYC(30)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .mute_n(mute_n),
        .supply_low(supply_low), .crossing_detect_enable(zc_en),
        .sign_right(sgn_r), .sign_left(sgn_l),
        .volume_word(volume_word), .gain_right(gain_right),
        .gain_left(gain_left), .soft_mute_right(sm_r),
        .soft_mute_left(sm_l), .hw_mute(hw_mute),
        .cal_busy(cal_busy), .por_busy(por_busy));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic exp_soft(input logic [7:0] code);
        return code == 8'h00;
    endfunction : exp_soft

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic wait_cal;
        for (i = 0; i < 80 && cal_busy !== 1'b0; i++) step(1);
        check(cal_busy, 16'h0000, "calibration end");
    endtask : wait_cal

    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        step(4);
        check(volume_word, 16'h0000, "reset word");
        check({sm_r, sm_l, por_busy, serial_out_en}, 16'h000E, "rst");
        @(posedge sys_clk);
        rst_n <= 1'b1;
        host.frame(32'h1, 1, 1'b1);
        check(volume_word, 16'h0000, "write in por");
        for (i = 0; i < 100 && por_busy !== 1'b0; i++) step(1);
        check(cal_busy, 16'h0001, "cal after por");
        wait_cal();
        check(hw_mute, 16'h0000, "mute off");
        prev_q = 16'h0000;
        for (int k = 0; k < 8; k++) begin
            w = (k < 4) ? corners[k] : 16'($random(seed));
            host.frame({16'h0000, w}, 16, 1'b1);
            step(6);
            check(volume_word, w, "latch");
            check(gain_right, w[15:8], "right code");
            check(gain_left, w[7:0], "left code");
            check(sm_r, exp_soft(w[15:8]), "soft mute r");
            check(sm_l, exp_soft(w[7:0]), "soft mute l");
            check(rd_word, prev_q, "readback");
            check(serial_out_en, 16'h0000, "release");
            prev_q = w;
        end
        host.frame(32'h1234, 16, 1'b0);
        step(6);
        check(volume_word, prev_q, "clock without select");
        a = 16'($random(seed));
        w = 16'($random(seed));
        host.frame({a, w}, 32, 1'b1);
        step(6);
        check(volume_word, w, "chain latch");
        check(rd_word, a, "chain pass");
        prev_q = w;
        zc_en <= 1'b1;
        w = ~prev_q;
        host.frame({16'h0000, w}, 16, 1'b1);
        step(4);
        check(gain_right, prev_q[15:8], "wait crossing");
        sgn_r <= 1'b1;
        step(6);
        sgn_r <= 1'b0;
        step(6);
        check(gain_right, w[15:8], "two crossings");
        check(gain_left, prev_q[7:0], "left waits");
        step(50);
        check(gain_left, w[7:0], "timeout");
        zc_en <= 1'b0;
        mute_n <= 1'b0;
        step(6);
        check({hw_mute, cal_busy}, 16'h0003, "mute cal");
        check(volume_word, 16'h0000, "mute clear");
        mute_n <= 1'b1;
        wait_cal();
        host.frame(32'h5A5A, 16, 1'b1);
        check(rd_word, 16'h0000, "shift cleared");
        supply_low <= 1'b1;
        step(6);
        check(hw_mute, 16'h0001, "low supply");
        supply_low <= 1'b0;
        step(6);
        check(cal_busy, 16'h0001, "supply back cal");
        check(volume_word, 16'h0000, "supply back clear");
        wait_cal();
        stop_test();
    end
endmodule : tb_stereo_volume_serial_control

`default_nettype wire
